// ===== hw/bog_map.svh
// offsets, field positions, reset values and timing counts of the overcurrent guard
// assumes the includer runs on the 125 MHz logic clock
`ifndef BOG_MAP_SVH
`define BOG_MAP_SVH

`define BOG_CLK_MHZ        125
// register offsets
`define BOG_OFF_STATUS     4'h0
`define BOG_OFF_MASK       4'h4
`define BOG_OFF_FLAGS      4'h8
// status and mask field positions
`define BOG_ST_TRIP_A      0
`define BOG_ST_TRIP_B      1
`define BOG_ST_TRIP_HS     2
`define BOG_ST_ERR_A       3
`define BOG_ST_ERR_B       4
`define BOG_ST_ERR_HS      5
`define BOG_ST_W           6
// flags register: writing this bit clears the error flags
`define BOG_FL_CLEAR       0
// reset values
`define BOG_RST_STATUS     6'h00
`define BOG_RST_MASK       6'h00
// blank times in ns, rounded up to whole clock cycles
`define BOG_BLANK_NS_0     600
`define BOG_BLANK_NS_1     900
`define BOG_BLANK_NS_2     1200
`define BOG_BLANK_NS_3     1500
`define BOG_CYC(ns)        (((ns) * `BOG_CLK_MHZ + 999) / 1000)
// error counter limits: trips to lockout, then lockout and quiet time in pwm cycles
`define BOG_TRIP_LIMIT     2'h3
`define BOG_LOCK_CYCLES    6'h3f
`define BOG_QUIET_LIMIT    7'h3f

`endif

// ===== hw/bog_pkg.sv
// types shared by the overcurrent guard modules
// assumes bog_map.svh provides all numeric constants
package bog_pkg;

    typedef enum logic [1:0] {
        BOG_BLANK_SHORT  = 2'h0,
        BOG_BLANK_LOWIND = 2'h1,
        BOG_BLANK_NORMAL = 2'h2,
        BOG_BLANK_SLOW   = 2'h3
    } bog_blank_sel_t;

    typedef enum logic {
        BOG_ERR_OK   = 1'b0,
        BOG_ERR_LOCK = 1'b1
    } bog_err_state_t;

    // one entry per error counter: low side a, low side b, high side
    typedef struct packed {
        logic hs;
        logic b;
        logic a;
    } bog_trio_t;

endpackage

// ===== hw/bog_blank_timer.sv
// blanking pulse timer for one bridge
// assumes start_in is a one-cycle pulse on each switching event
`timescale 1ns/10ps
`default_nettype none
`include "bog_map.svh"

module bog_blank_timer
    import bog_pkg::*;
(
    input  wire logic           mclk_in,
    input  wire logic           rst_in,
    input  wire logic           start_in,
    input  wire bog_blank_sel_t sel_in,
    output var  logic           blank_out
);

    logic [7:0] cnt_reg;
    logic       blank_reg;
    logic [7:0] term;

    // terminal count chosen by the select pins
    always_comb begin
        unique case (sel_in)
            BOG_BLANK_SHORT:  term = 8'(`BOG_CYC(`BOG_BLANK_NS_0));
            BOG_BLANK_LOWIND: term = 8'(`BOG_CYC(`BOG_BLANK_NS_1));
            BOG_BLANK_NORMAL: term = 8'(`BOG_CYC(`BOG_BLANK_NS_2));
            BOG_BLANK_SLOW:   term = 8'(`BOG_CYC(`BOG_BLANK_NS_3));
        endcase
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            cnt_reg   <= 8'h00;
            blank_reg <= 1'b0;
        end else if (start_in) begin
            cnt_reg   <= term - 8'h01;
            blank_reg <= 1'b1;
        end else if (cnt_reg != 8'h00) begin
            cnt_reg <= cnt_reg - 8'h01;
        end else begin
            blank_reg <= 1'b0;
        end
    end

    assign blank_out = blank_reg;

endmodule
`default_nettype wire

// ===== hw/bog_err_counter.sv
// one overcurrent error counter with lockout and quiet-time reset
// assumes trip_in and cycle_in are one-cycle pulses on the logic clock
`timescale 1ns/10ps
`default_nettype none
`include "bog_map.svh"

module bog_err_counter
    import bog_pkg::*;
(
    input  wire logic       mclk_in,
    input  wire logic       rst_in,
    input  wire logic       trip_in,
    input  wire logic       cycle_in,
    input  wire logic       clear_in,
    output var  logic       lock_out,
    output var  logic       flag_out,
    output var  logic [1:0] count_out
);

    bog_err_state_t state_reg;
    logic [1:0]     count_reg;
    logic [5:0]     lock_reg;
    logic [6:0]     quiet_reg;
    logic           flag_reg;
    wire            to_lock = trip_in && state_reg == BOG_ERR_OK
                              && count_reg == `BOG_TRIP_LIMIT - 2'h1;

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            state_reg <= BOG_ERR_OK;
            count_reg <= 2'h0;
            lock_reg  <= 6'h00;
            quiet_reg <= 7'h00;
            flag_reg  <= 1'b0;
        end else if (to_lock) begin
            // a lockout that starts now wins over a clear in the same cycle
            state_reg <= BOG_ERR_LOCK;
            count_reg <= `BOG_TRIP_LIMIT;
            lock_reg  <= `BOG_LOCK_CYCLES;
            quiet_reg <= 7'h00;
            flag_reg  <= 1'b1;
        end else if (clear_in) begin
            state_reg <= BOG_ERR_OK;
            count_reg <= 2'h0;
            lock_reg  <= 6'h00;
            quiet_reg <= 7'h00;
            flag_reg  <= 1'b0;
        end else begin
            unique case (state_reg)
                BOG_ERR_OK: begin
                    if (trip_in) begin
                        count_reg <= count_reg + 2'h1;
                        quiet_reg <= 7'h00;
                    end else if (cycle_in) begin
                        if (quiet_reg == `BOG_QUIET_LIMIT) begin
                            count_reg <= 2'h0;
                        end else begin
                            quiet_reg <= quiet_reg + 7'h01;
                        end
                    end
                end
                BOG_ERR_LOCK: begin
                    if (cycle_in) begin
                        lock_reg <= lock_reg - 6'h01;
                        if (lock_reg == 6'h01) begin
                            state_reg <= BOG_ERR_OK;
                            count_reg <= 2'h0;
                        end
                    end
                end
            endcase
        end
    end

    assign lock_out  = state_reg == BOG_ERR_LOCK;
    assign flag_out  = flag_reg;
    assign count_out = count_reg;

endmodule
`default_nettype wire

// ===== hw/bog_guard.sv
// blanking and overcurrent guard for a two-bridge chopper driver
// assumes comparator outputs, oscillator and straps arrive as raw pins;
// the serial word strobe comes from logic on the same clock
`timescale 1ns/10ps
`default_nettype none
`include "bog_map.svh"

module bog_guard
    import bog_pkg::*;
(
    input  wire logic       mclk_in,
    input  wire logic       rst_in,
    // pins from outside the clock domain
    input  wire logic       osc_pin_in,
    input  wire logic       blank_select_low_in,
    input  wire logic       blank_select_high_in,
    input  wire logic       enable_active_low_pin_in,
    input  wire logic       polarity_a_in,
    input  wire logic       polarity_b_in,
    input  wire logic       chop_cmp_a_in,
    input  wire logic       chop_cmp_b_in,
    input  wire logic       lowside_trip_a_in,
    input  wire logic       lowside_trip_b_in,
    input  wire logic       highside_trip_in,
    // serial telegram decoder, same clock
    input  wire logic       word_strobe_in,
    input  wire logic [3:0] coil_word_a_in,
    input  wire logic [3:0] coil_word_b_in,
    // register port
    input  wire logic [3:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic       reg_wr_in,
    input  wire logic       reg_rd_in,
    output var  logic [7:0] reg_rdata_out,
    // chopper side
    output var  logic       cycle_start_a_out,
    output var  logic       cycle_start_b_out,
    output var  logic       blank_a_out,
    output var  logic       blank_b_out,
    output var  logic       chop_end_a_out,
    output var  logic       chop_end_b_out,
    output var  logic       bridge_off_a_out,
    output var  logic       bridge_off_b_out,
    output var  logic [2:0] error_flags_out,
    output var  logic       irq_out
);

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers
    localparam int NSYNC = 11;

    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] sync1_reg;
    logic [NSYNC-1:0] sync2_reg;

    assign pin_raw = {highside_trip_in, lowside_trip_b_in,
                      lowside_trip_a_in, chop_cmp_b_in, chop_cmp_a_in,
                      polarity_b_in, polarity_a_in,
                      enable_active_low_pin_in, blank_select_high_in,
                      blank_select_low_in, osc_pin_in};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge mclk_in) begin
                if (rst_in) begin
                    sync1_reg[gi] <= 1'b0;
                    sync2_reg[gi] <= 1'b0;
                end else begin
                    sync1_reg[gi] <= pin_raw[gi];
                    sync2_reg[gi] <= sync1_reg[gi];
                end
            end
        end
    endgenerate

    wire            osc_s     = sync2_reg[0];
    wire            enn_s     = sync2_reg[3];
    wire            pol_a_s   = sync2_reg[4];
    wire            pol_b_s   = sync2_reg[5];
    wire            chop_a_s  = sync2_reg[6];
    wire            chop_b_s  = sync2_reg[7];
    wire            ls_a_s    = sync2_reg[8];
    wire            ls_b_s    = sync2_reg[9];
    wire            hs_s      = sync2_reg[10];
    wire            disabled  = enn_s;
    bog_blank_sel_t blank_sel;

    assign blank_sel = bog_blank_sel_t'(sync2_reg[2:1]);

    ////////////////////////////////////////////////////////////////////
    // pwm cycle starts and blanking
    logic osc_d_reg;
    logic pol_a_d_reg;
    logic pol_b_d_reg;

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            osc_d_reg   <= 1'b0;
            pol_a_d_reg <= 1'b0;
            pol_b_d_reg <= 1'b0;
        end else begin
            osc_d_reg   <= osc_s;
            pol_a_d_reg <= pol_a_s;
            pol_b_d_reg <= pol_b_s;
        end
    end

    wire osc_rise  = osc_s & ~osc_d_reg;
    wire osc_fall  = ~osc_s & osc_d_reg;
    wire pol_a_chg = pol_a_s ^ pol_a_d_reg;
    wire pol_b_chg = pol_b_s ^ pol_b_d_reg;
    wire start_a   = osc_rise | pol_a_chg;
    wire start_b   = osc_fall | pol_b_chg;

    logic [1:0] start_v;
    logic [1:0] blank_v;

    assign start_v = {start_b, start_a};

    // each bridge blanks after its own switching event
    generate
        for (gi = 0; gi < 2; gi++) begin : g_blank
            bog_blank_timer u_blank (
                .mclk_in   (mclk_in),
                .rst_in    (rst_in),
                .start_in  (start_v[gi]),
                .sel_in    (blank_sel),
                .blank_out (blank_v[gi])
            );
        end
    endgenerate

    wire blank_a  = blank_v[0];
    wire blank_b  = blank_v[1];
    wire blank_hs = blank_a | blank_b;

    ////////////////////////////////////////////////////////////////////
    // overcurrent qualification and cycle shutoff
    logic cyc_off_a_reg;
    logic cyc_off_b_reg;

    // one count per event: a bridge already off this cycle adds none
    wire trip_a  = ls_a_s & ~blank_a & ~cyc_off_a_reg;
    wire trip_b  = ls_b_s & ~blank_b & ~cyc_off_b_reg;
    wire trip_hs = hs_s & ~blank_hs
                   & ~(cyc_off_a_reg & cyc_off_b_reg);

    bog_trio_t trip;
    bog_trio_t cyc_tick;
    bog_trio_t lock;
    bog_trio_t flag;
    logic [5:0] cnt_all;

    assign trip     = '{hs: trip_hs & ~disabled, b: trip_b & ~disabled,
                        a: trip_a & ~disabled};
    assign cyc_tick = '{hs: osc_rise, b: osc_fall, a: osc_rise};

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            cyc_off_a_reg <= 1'b0;
            cyc_off_b_reg <= 1'b0;
        end else begin
            // a trip holds the bridge off until its next cycle start
            if (trip_a | trip_hs) begin
                cyc_off_a_reg <= 1'b1;
            end else if (start_a) begin
                cyc_off_a_reg <= 1'b0;
            end
            if (trip_b | trip_hs) begin
                cyc_off_b_reg <= 1'b1;
            end else if (start_b) begin
                cyc_off_b_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // error counters and flag clearing
    logic enn_d_reg;
    logic sw_clear;

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            enn_d_reg <= 1'b0;
        end else begin
            enn_d_reg <= enn_s;
        end
    end

    wire reenable   = enn_d_reg & ~enn_s;
    wire zero_words = word_strobe_in && coil_word_a_in == 4'h0
                      && coil_word_b_in == 4'h0;
    wire err_clear  = disabled | reenable | zero_words | sw_clear;

    generate
        for (gi = 0; gi < 3; gi++) begin : g_err
            bog_err_counter u_err (
                .mclk_in   (mclk_in),
                .rst_in    (rst_in),
                .trip_in   (trip[gi]),
                .cycle_in  (cyc_tick[gi]),
                .clear_in  (err_clear),
                .lock_out  (lock[gi]),
                .flag_out  (flag[gi]),
                .count_out (cnt_all[2*gi+1:2*gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // register port, status and interrupt
    logic [`BOG_ST_W-1:0] status_reg;
    logic [`BOG_ST_W-1:0] status_next;
    logic [`BOG_ST_W-1:0] mask_reg;
    logic [`BOG_ST_W-1:0] status_set;
    logic [`BOG_ST_W-1:0] w1c;
    logic [2:0]           flag_d_reg;
    logic [7:0]           rdata_reg;
    logic [7:0]           rd_mux;

    wire wr_status = reg_wr_in && reg_addr_in == `BOG_OFF_STATUS;
    wire wr_mask   = reg_wr_in && reg_addr_in == `BOG_OFF_MASK;
    wire wr_flags  = reg_wr_in && reg_addr_in == `BOG_OFF_FLAGS;

    assign sw_clear    = wr_flags & reg_wdata_in[`BOG_FL_CLEAR];
    assign w1c         = wr_status ? reg_wdata_in[`BOG_ST_W-1:0]
                                   : '0;
    // error events are the rising edges of the three flags
    assign status_set  = {flag & ~flag_d_reg, trip.hs, trip.b, trip.a};
    // a new event wins over its own clear
    assign status_next = (status_reg & ~w1c) | status_set;

    assign rd_mux = (reg_addr_in == `BOG_OFF_STATUS) ?
                        {2'h0, status_reg} :
                    (reg_addr_in == `BOG_OFF_MASK) ?
                        {2'h0, mask_reg} :
                    (reg_addr_in == `BOG_OFF_FLAGS) ?
                        {cnt_all[5:2], 1'b0, flag} :
                        8'h00;

    always_ff @(posedge mclk_in) begin
        if (rst_in | disabled) begin
            status_reg <= `BOG_RST_STATUS;
            mask_reg   <= `BOG_RST_MASK;
            flag_d_reg <= 3'h0;
            rdata_reg  <= 8'h00;
        end else begin
            status_reg <= status_next;
            flag_d_reg <= flag;
            if (wr_mask) begin
                mask_reg <= reg_wdata_in[`BOG_ST_W-1:0];
            end
            rdata_reg <= reg_rd_in ? rd_mux : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs
    logic [1:0] start_o_reg;
    logic [1:0] chop_o_reg;
    logic [1:0] off_o_reg;

    // comparator is blind during blanking, so on time never ends sooner
    wire chop_end_a = chop_a_s & ~blank_a & ~disabled;
    wire chop_end_b = chop_b_s & ~blank_b & ~disabled;
    wire off_a      = disabled | cyc_off_a_reg | lock.a | lock.hs;
    wire off_b      = disabled | cyc_off_b_reg | lock.b | lock.hs;

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            start_o_reg <= 2'h0;
            chop_o_reg  <= 2'h0;
            off_o_reg   <= 2'h3;
        end else begin
            start_o_reg <= start_v;
            chop_o_reg  <= {chop_end_b, chop_end_a};
            off_o_reg   <= {off_b, off_a};
        end
    end

    assign cycle_start_a_out = start_o_reg[0];
    assign cycle_start_b_out = start_o_reg[1];
    assign blank_a_out       = blank_a;
    assign blank_b_out       = blank_b;
    assign chop_end_a_out    = chop_o_reg[0];
    assign chop_end_b_out    = chop_o_reg[1];
    assign bridge_off_a_out  = off_o_reg[0];
    assign bridge_off_b_out  = off_o_reg[1];
    assign error_flags_out   = flag;
    assign irq_out           = |(status_reg & mask_reg);
    assign reg_rdata_out     = rdata_reg;

endmodule
`default_nettype wire

// ===== dv/bog_bridge_model.sv
// behavioural external bridges with their sense resistors
// assumes the bench raises a short input to inject fault current
`timescale 1ns/10ps
`default_nettype none

module bog_bridge_model (
    input  wire logic mclk_in,
    input  wire logic off_a_in,
    input  wire logic off_b_in,
    input  wire logic short_a_in,
    input  wire logic short_b_in,
    input  wire logic short_hs_in,
    output var  logic trip_a_out,
    output var  logic trip_b_out,
    output var  logic trip_hs_out,
    output var  logic cur_a_out,
    output var  logic cur_b_out
);
    logic [4:0] on_a_reg;
    logic [4:0] on_b_reg;

    // fault current flows only while a bridge conducts
    assign trip_a_out  = short_a_in && !off_a_in;
    assign trip_b_out  = short_b_in && !off_b_in;
    assign trip_hs_out = short_hs_in && !(off_a_in && off_b_in);
    // current settles well inside the shortest blank
    assign cur_a_out   = on_a_reg[4];
    assign cur_b_out   = on_b_reg[4];

    always_ff @(posedge mclk_in) begin
        on_a_reg <= off_a_in ? 5'h00 : on_a_reg + {4'h0, !on_a_reg[4]};
        on_b_reg <= off_b_in ? 5'h00 : on_b_reg + {4'h0, !on_b_reg[4]};
    end
endmodule
`default_nettype wire

// ===== dv/bog_guard_assertions.sv
// concurrent checks on the guard's ports
// assumes the blank select straps stay steady while a blank runs
`timescale 1ns/10ps
`default_nettype none

module bog_guard_assertions (
    input wire logic       mclk_in,
    input wire logic       rst_in,
    input wire logic       blank_select_low_in,
    input wire logic       blank_select_high_in,
    input wire logic       enable_active_low_pin_in,
    input wire logic       lowside_trip_a_in,
    input wire logic       highside_trip_in,
    input wire logic       reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic       cycle_start_a_out,
    input wire logic       cycle_start_b_out,
    input wire logic       blank_a_out,
    input wire logic       blank_b_out,
    input wire logic       chop_end_a_out,
    input wire logic       bridge_off_a_out,
    input wire logic       bridge_off_b_out,
    input wire logic [2:0] error_flags_out
);
    logic [7:0] run_a_reg;
    logic [7:0] run_b_reg;
    logic [7:0] exp_n;
    logic       enable_active_low_pin;

    assign enable_active_low_pin   = enable_active_low_pin_in;
    assign exp_n = blank_select_high_in ? (blank_select_low_in ? 8'hbc : 8'h96)
                                        : (blank_select_low_in ? 8'h71 : 8'h4b);

    // blank run lengths
    always_ff @(posedge mclk_in) begin
        run_a_reg <= (rst_in || !blank_a_out) ? 8'h00 : run_a_reg + 8'h01;
        run_b_reg <= (rst_in || !blank_b_out) ? 8'h00 : run_b_reg + 8'h01;
    end

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    blank_len_a_a: assert property ($fell(blank_a_out) && !enable_active_low_pin |-> run_a_reg == exp_n)
        else $error("blank a length off");
    blank_len_b_a: assert property ($fell(blank_b_out) && !enable_active_low_pin |-> run_b_reg == exp_n)
        else $error("blank b length off");
    chop_mask_a: assert property (blank_a_out && $past(blank_a_out) |-> !chop_end_a_out)
        else $error("chop end during blank");
    start_blank_a: assert property (cycle_start_a_out && !enable_active_low_pin |-> ##[0:1] blank_a_out)
        else $error("start without blank");
    trip_off_a: assert property ((lowside_trip_a_in && !blank_a_out && !enable_active_low_pin) [*4] |-> ##[0:2] bridge_off_a_out)
        else $error("low side trip ignored");
    hs_off_a: assert property ((highside_trip_in && !blank_a_out && !blank_b_out && !enable_active_low_pin) [*4]
                               |-> ##[0:2] (bridge_off_a_out && bridge_off_b_out))
        else $error("high side trip ignored");
    off_release_a: assert property ($fell(bridge_off_a_out) && !$past(rst_in, 2) && !$past(enable_active_low_pin, 4)
                                    && !$past(error_flags_out[0] || error_flags_out[2], 2)
                                    |-> cycle_start_a_out || $past(cycle_start_a_out) || $past(cycle_start_a_out, 2))
        else $error("bridge a freed mid cycle");
    disabled_a: assert property (enable_active_low_pin [*4] |=> bridge_off_a_out && bridge_off_b_out && error_flags_out == 3'h0)
        else $error("disabled guard not quiet");
    rdata_idle_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
        else $error("read data outside read");
    start_split_a: assert property (cycle_start_a_out |-> !cycle_start_b_out)
        else $error("both bridges start together");
endmodule

bind bog_guard bog_guard_assertions chk_u (.*);
`default_nettype wire

// ===== dv/bog_guard_test.sv
// self-checking bench for the blanking and overcurrent guard
// assumes bog_bridge_model stands for the bridges; osc half period is 100 clocks in osc_run
`timescale 1ns/10ps
`default_nettype none
`include "bog_map.svh"

module bog_guard_test;
    logic       mclk_in, rst_in, osc_pin_in, blank_select_low_in, blank_select_high_in;
    logic       enable_active_low_pin_in, polarity_a_in, polarity_b_in, word_strobe_in;
    logic [3:0] coil_word_a_in, coil_word_b_in, reg_addr_in;
    logic [7:0] reg_wdata_in, reg_rdata_out;
    logic       reg_wr_in, reg_rd_in, cycle_start_a_out, cycle_start_b_out, blank_a_out, blank_b_out;
    logic       chop_end_a_out, chop_end_b_out, bridge_off_a_out, bridge_off_b_out, irq_out;
    logic       chop_cmp_a_in, chop_cmp_b_in, lowside_trip_a_in, lowside_trip_b_in, highside_trip_in;
    logic       short_a, short_b, short_hs;
    logic [2:0] error_flags_out;
    logic [7:0] blank_exp [4] = '{8'h4b, 8'h71, 8'h96, 8'hbc};
    int         err_count = 0, check_count = 0, n;

    bog_guard dut_u (.*);

    bog_bridge_model model_u (.mclk_in, .off_a_in(bridge_off_a_out), .off_b_in(bridge_off_b_out),
        .short_a_in(short_a), .short_b_in(short_b), .short_hs_in(short_hs),
        .trip_a_out(lowside_trip_a_in), .trip_b_out(lowside_trip_b_in), .trip_hs_out(highside_trip_in),
        .cur_a_out(chop_cmp_a_in), .cur_b_out(chop_cmp_b_in));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // steps end just after an edge, clear of sampling
    task automatic tick(input int k);
        repeat (k) @(posedge mclk_in);
        #1;
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
        tick(1);
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        reg_wr_in    <= 1'b1;
        tick(1);
        reg_wr_in    <= 1'b0;
        tick(1);
    endtask

    task automatic reg_read(input logic [3:0] a, input string what, input logic [7:0] exp);
        tick(1);
        reg_addr_in <= a;
        reg_rd_in   <= 1'b1;
        tick(1);
        reg_rd_in   <= 1'b0;
        chk(what, reg_rdata_out, exp);
    endtask

    task automatic osc_run(input int k);
        repeat (k) begin
            osc_pin_in <= 1'b1;
            tick(100);
            osc_pin_in <= 1'b0;
            tick(100);
        end
    endtask

    task automatic telegram(input logic [3:0] a);
        coil_word_a_in <= a;
        coil_word_b_in <= 4'h0;
        word_strobe_in <= 1'b1;
        tick(1);
        word_strobe_in <= 1'b0;
        tick(3);
    endtask

    // three trips in a row lock bridge a
    task automatic lock_a;
        short_a <= 1'b1;
        osc_run(3);
        short_a <= 1'b0;
        chk("flags locked", 8'(error_flags_out), 8'h01);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        mclk_in = 1'b0;
        forever #4 mclk_in = ~mclk_in;
    end

    initial begin
        {rst_in, osc_pin_in, blank_select_low_in, blank_select_high_in, enable_active_low_pin_in} = 5'h10;
        {polarity_a_in, polarity_b_in, word_strobe_in, reg_wr_in, reg_rd_in} = 5'h00;
        {coil_word_a_in, coil_word_b_in, reg_addr_in, reg_wdata_in} = 20'h00000;
        {short_a, short_b, short_hs} = 3'h0;
        tick(20);
        chk("off during reset", 8'({bridge_off_b_out, bridge_off_a_out}), 8'h03);
        rst_in <= 1'b0;
        tick(2);
        reg_read(`BOG_OFF_STATUS, "status reset", 8'h00);
        reg_read(`BOG_OFF_MASK, "mask reset", 8'h00);
        reg_read(4'hc, "unmapped read", 8'h00);
        for (int s = 0; s < 4; s++) begin
            {blank_select_high_in, blank_select_low_in} <= s[1:0];
            tick(10);
            osc_pin_in <= 1'b1;
            for (n = 0; blank_a_out !== 1'b1 && n < 20; n++)
                tick(1);
            for (n = 0; blank_a_out === 1'b1 && n < 300; n++)
                tick(1);
            if (n == 0 || n == 300) begin
                err_count++;
                test_done;
            end
            chk("blank cycles", n[7:0], blank_exp[s]);
            tick(3);
            chk("chop after blank", 8'({chop_end_b_out, chop_end_a_out}), 8'h03);
            osc_pin_in <= 1'b0;
            tick(200);
        end
        {blank_select_high_in, blank_select_low_in} <= 2'h0;
        tick(10);
        polarity_a_in <= 1'b1;
        for (n = 0; cycle_start_a_out !== 1'b1 && n < 8; n++)
            tick(1);
        chk("polarity restart", 8'(cycle_start_a_out), 8'h01);
        tick(2);
        chk("restart blank", 8'(blank_a_out), 8'h01);
        tick(100);
        // spike inside blank must not trip
        osc_pin_in <= 1'b1;
        tick(10);
        short_a <= 1'b1;
        tick(20);
        short_a <= 1'b0;
        tick(90);
        chk("blanked trip", 8'(bridge_off_a_out), 8'h00);
        osc_pin_in <= 1'b0;
        tick(100);
        short_a <= 1'b1;
        tick(10);
        chk("trip off", 8'(bridge_off_a_out), 8'h01);
        reg_read(`BOG_OFF_STATUS, "trip status", 8'h01);
        osc_run(1);
        chk("two trips", 8'(error_flags_out), 8'h00);
        osc_run(1);
        short_a <= 1'b0;
        chk("third trip", 8'(error_flags_out), 8'h01);
        reg_read(`BOG_OFF_FLAGS, "flags reg", 8'h01);
        osc_run(10);
        chk("lockout", 8'({bridge_off_b_out, bridge_off_a_out}), 8'h01);
        reg_read(`BOG_OFF_STATUS, "error status", 8'h09);
        chk("irq masked", 8'(irq_out), 8'h00);
        reg_write(`BOG_OFF_MASK, 8'h08);
        chk("irq raised", 8'(irq_out), 8'h01);
        reg_write(`BOG_OFF_STATUS, 8'h09);
        chk("irq cleared", 8'(irq_out), 8'h00);
        reg_write(`BOG_OFF_FLAGS, 8'h01);
        chk("flag clear", 8'(error_flags_out), 8'h00);
        osc_run(1);
        chk("early release", 8'(bridge_off_a_out), 8'h00);
        short_b <= 1'b1;
        tick(10);
        short_b <= 1'b0;
        reg_read(`BOG_OFF_FLAGS, "count b one", 8'h10);
        osc_run(63);
        reg_read(`BOG_OFF_FLAGS, "count b kept", 8'h10);
        osc_run(1);
        reg_read(`BOG_OFF_FLAGS, "count b zero", 8'h00);
        // high side spike while only bridge a blanks
        osc_pin_in <= 1'b1;
        tick(10);
        short_hs <= 1'b1;
        tick(20);
        short_hs <= 1'b0;
        tick(90);
        chk("hs blanked", 8'({bridge_off_b_out, bridge_off_a_out}), 8'h00);
        osc_pin_in <= 1'b0;
        tick(100);
        short_hs <= 1'b1;
        tick(10);
        short_hs <= 1'b0;
        chk("hs both off", 8'({bridge_off_b_out, bridge_off_a_out}), 8'h03);
        reg_read(`BOG_OFF_FLAGS, "count hs one", 8'h40);
        lock_a;
        telegram(4'h1);
        chk("nonzero words", 8'(error_flags_out), 8'h01);
        telegram(4'h0);
        chk("zero words", 8'(error_flags_out), 8'h00);
        lock_a;
        enable_active_low_pin_in <= 1'b1;
        tick(10);
        chk("disabled flags", 8'(error_flags_out), 8'h00);
        chk("disabled off", 8'({bridge_off_b_out, bridge_off_a_out}), 8'h03);
        reg_write(`BOG_OFF_MASK, 8'h3f);
        enable_active_low_pin_in <= 1'b0;
        tick(10);
        reg_read(`BOG_OFF_MASK, "mask after disable", 8'h00);
        reg_read(`BOG_OFF_STATUS, "status after disable", 8'h00);
        test_done;
    end
endmodule
`default_nettype wire
